//--- hw/dma_engine_consts.svh
// register offsets, field positions, reset values and counts of the transfer engine status block
`ifndef DMA_ENGINE_CONSTS_SVH
`define DMA_ENGINE_CONSTS_SVH

`define ADDR_ENGINE_STATUS  12'h100
`define ADDR_ERROR_FLAGS    12'h120
`define ADDR_ERROR_MASK     12'h124
`define ADDR_ERROR_CLEAR    12'h128
`define ADDR_ERROR_DETAIL   12'h12C
`define ADDR_ERROR_COMMAND  12'h130
`define ADDR_READ_PACING    12'h140
`define ADDR_ACTIVE_OPTIONS 12'h240
`define DQ_PAGE             4'h3
`define DQ_STRIDE_BITS      6

`define ST_WRITE_PENDING    2
`define ST_SOURCE_ACTIVE    1
`define ST_PROGRAM_BUSY     0
`define ST_ALWAYS_ONE       8

`define ERR_ADDR_FAULT      3
`define ERR_REQUEST_FAULT   2
`define ERR_BUS_FAULT       0
`define ERR_IMPLEMENTED     4'hD
`define ERROR_RECHECK_BIT            0

`define MASK_RESET          4'h0
`define PACING_RESET        3'h0
`define FWID_MAX            3'h5

`define DEPTH_INSTANCE_ZERO 3'h2
`define DEPTH_OTHER         3'h4

`endif

//--- hw/dma_engine_pkg.sv
// types shared by the transfer engine status block
package dma_engine_pkg;

  typedef struct packed {
    logic       rd;
    logic       wr;
    logic [11:0] addr;
    logic [31:0] wdata;
  } reg_req_t;

  typedef struct packed {
    logic       completion_chaining_enable;
    logic       completion_interrupt_enable;
    logic [5:0] completion_code;
    logic [2:0] fifo_width;
    logic       dest_addr_mode;
    logic       source_addr_mode;
  } opts_t;

  typedef struct packed {
    opts_t       opts;
    logic [4:0]  src_addr_low;
    logic [4:0]  dst_addr_low;
    logic [15:0] first_dim_bytes;
    logic [15:0] second_dim_count;
  } move_request_t;

  typedef struct packed {
    logic       valid;
    logic [3:0] code;
  } bus_status_t;

  typedef struct packed {
    logic [31:0]     rdata;
    logic [3:0]      flags;
    logic [3:0]      mask;
    logic [17:0]     detail;
    logic [2:0]      pacing;
    logic            prog_busy;
    move_request_t   prog;
    logic            src_busy;
    opts_t           src_opts;
    logic [15:0]     src_left;
    logic [5:0]      gap;
    opts_t [3:0]     dq;
    logic [1:0]      dq_head;
    logic [2:0]      dq_count;
    logic [7:0]      wr_pending;
    logic            read_cmd;
    logic            irq;
    logic            error_recheck_gap;
  } state_t;

endpackage

//--- hw/dma_engine_status.sv
// status, error capture and read pacing of one dma transfer engine
// Overview of operation
// - status bit 2 is high while any issued write still awaits its status
// - status bit 1 is high while the source side services a move request
// - status bit 0 shows program set occupied; controller loads only when idle
// - flag bit 3 sets on a register access to an unmapped address
// - flag bit 2 sets on zero counts or misaligned constant addressing
// - flag bit 0 sets on a returned bus error and records its details
// - interrupt is high while any flag is set with its mask bit set
// - clearing bit 3 or 2 drops that flag only, detail kept; zeros do nothing
// - clearing bit 0 drops the bus flag and wipes the detail register
// - detail keeps chaining enable at 17, interrupt enable at 16, code at 13:8
// - detail bits 3:0 keep the nonzero status; 1-7 read, 8-F write
// - same-cycle statuses: take the nonzero one, write wins if both
// - writing 1 to command bit 0 pulses the interrupt line if any flag set
// - read gap applies within a request and across requests alike
// - pacing 0 back to back; 1-4 give 4, 8, 16, 32 cycles; 5-7 reserved
// - a pacing of N cycles leaves N minus one idle cycles between reads
// - destination queue sets equal its depth: 2 on instance zero, else 4
// - only the controller loads the program set; debug views ignore writes
//
// Chosen here: the placing of the registers and the strobed register port.
`timescale 1ns/1ps
`include "dma_engine_consts.svh"

module dma_engine_status
  import dma_engine_pkg::*;
#(
  parameter int unsigned INSTANCE = 0
)
(
  input  wire logic          clk,
  input  wire logic          reset,
  input  wire reg_req_t      reg_bus,
  output logic [31:0]        read_data,
  input  wire logic          load_valid,
  input  wire move_request_t load_req,
  input  wire bus_status_t   read_status,
  input  wire bus_status_t   write_status,
  input  wire logic          write_issued,
  input  wire logic          dest_done,
  output logic               program_set_occupied,
  output logic               read_cmd,
  output logic               error_irq
);

  // queue depth follows the instance number
  localparam logic [2:0] DQ_DEPTH = (INSTANCE == 0) ? `DEPTH_INSTANCE_ZERO : `DEPTH_OTHER;
  localparam logic [1:0] DQ_WRAP  = 2'(DQ_DEPTH - 3'h1);

  state_t s;
  state_t next_state;

  logic        addr_valid;
  logic [31:0] read_value;
  logic        req_bad;
  logic        bus_evt;
  logic [3:0]  bus_code;
  opts_t       bus_opts;
  logic [3:0]  flag_set;
  logic [3:0]  flag_clr;
  logic        error_recheck_now;
  logic [5:0]  gap_load;
  logic        move_now;
  logic        pop_now;
  logic        irq_cause;

  function automatic logic [31:0] opts_word(input opts_t o);
    opts_word = {9'h000, o.completion_chaining_enable, 1'b0, o.completion_interrupt_enable,
                 2'h0, o.completion_code, 1'b0, o.fifo_width, 6'h00,
                 o.dest_addr_mode, o.source_addr_mode};
  endfunction

  // constant addressing needs both address and first count aligned to the fifo width
  function automatic logic misaligned(input logic [4:0] a, input logic [15:0] cnt,
                                      input logic [2:0] w);
    logic [4:0] m;
    m = 5'((6'h01 << w) - 6'h01);
    misaligned = ((a & m) != 5'h00) || ((cnt[4:0] & m) != 5'h00);
  endfunction

  // register decode; destination queue views live in one page, one set per stride
  always_comb
  begin
    addr_valid = 1'b1;
    read_value = 32'h0000_0000;
    case (reg_bus.addr)
      `ADDR_ENGINE_STATUS:
      begin
        read_value[13:12]              = s.dq_head;
        read_value[`ST_ALWAYS_ONE]     = 1'b1;
        read_value[6:4]                = s.dq_count;
        read_value[`ST_WRITE_PENDING]  = (s.wr_pending != 8'h00);
        read_value[`ST_SOURCE_ACTIVE]  = s.src_busy;
        read_value[`ST_PROGRAM_BUSY]   = s.prog_busy;
      end
      `ADDR_ERROR_FLAGS:    read_value[3:0]  = s.flags;
      `ADDR_ERROR_MASK:     read_value[3:0]  = s.mask;
      `ADDR_ERROR_DETAIL:   read_value[17:0] = s.detail;
      `ADDR_READ_PACING:    read_value[2:0]  = s.pacing;
      `ADDR_ACTIVE_OPTIONS: read_value       = opts_word(s.src_opts);
      `ADDR_ERROR_CLEAR,
      `ADDR_ERROR_COMMAND:  read_value       = 32'h0000_0000;
      default:
      begin
        addr_valid = 1'b0;
        for (int i = 0; i < 4; i++)
        begin
          if (reg_bus.addr[11:8] == `DQ_PAGE && reg_bus.addr[5:0] == 6'h00 &&
              reg_bus.addr[7:6] == 2'(i) && 3'(i) < DQ_DEPTH)
          begin
            addr_valid = 1'b1;
            read_value = opts_word(s.dq[i]);
          end
        end
      end
    endcase
  end

  always_comb
  begin
    next_state = s;
    next_state.read_cmd = 1'b0;
    next_state.rdata    = 32'h0000_0000;
    flag_set = 4'h0;
    flag_clr = 4'h0;
    error_recheck_now = 1'b0;

    if (reg_bus.rd)
    begin
      next_state.rdata = read_value;
    end
    // status and debug views have no write path at all
    if (reg_bus.wr)
    begin
      case (reg_bus.addr)
        `ADDR_ERROR_MASK:    next_state.mask   = reg_bus.wdata[3:0] & `ERR_IMPLEMENTED;
        `ADDR_READ_PACING:   next_state.pacing = reg_bus.wdata[2:0];
        `ADDR_ERROR_CLEAR:   flag_clr = reg_bus.wdata[3:0] & `ERR_IMPLEMENTED;
        `ADDR_ERROR_COMMAND: error_recheck_now = reg_bus.wdata[`ERROR_RECHECK_BIT];
        default:             flag_clr = 4'h0;
      endcase
    end
    flag_set[`ERR_ADDR_FAULT] = (reg_bus.rd | reg_bus.wr) & ~addr_valid;

    // request check at load; a faulty request is dropped, never occupies the set
    req_bad = (load_req.first_dim_bytes == 16'h0000) || (load_req.second_dim_count == 16'h0000)
           || ((load_req.opts.source_addr_mode || load_req.opts.dest_addr_mode) &&
               ((load_req.opts.fifo_width > `FWID_MAX) ||
                (load_req.opts.source_addr_mode &&
                 misaligned(load_req.src_addr_low, load_req.first_dim_bytes,
                            load_req.opts.fifo_width)) ||
                (load_req.opts.dest_addr_mode &&
                 misaligned(load_req.dst_addr_low, load_req.first_dim_bytes,
                            load_req.opts.fifo_width))));
    flag_set[`ERR_REQUEST_FAULT] = load_valid & req_bad;
    // a load while occupied breaks the controller's side and is dropped
    if (load_valid && !req_bad && !s.prog_busy)
    begin
      next_state.prog_busy = 1'b1;
      next_state.prog      = load_req;
    end

    // write status outranks read status when both are nonzero
    bus_evt  = 1'b0;
    bus_code = 4'h0;
    bus_opts = s.src_opts;
    if (read_status.valid && read_status.code != 4'h0)
    begin
      bus_evt  = 1'b1;
      bus_code = read_status.code;
    end
    if (write_status.valid && write_status.code != 4'h0)
    begin
      bus_evt  = 1'b1;
      bus_code = write_status.code;
      bus_opts = s.dq[s.dq_head];
    end
    flag_set[`ERR_BUS_FAULT] = bus_evt;

    // set beats clear in the same cycle
    next_state.flags = (s.flags & ~flag_clr) | flag_set;
    if (flag_clr[`ERR_BUS_FAULT])
    begin
      next_state.detail = 18'h00000;
    end
    // first bus error is kept until software clears it
    if (bus_evt && (!s.flags[`ERR_BUS_FAULT] || flag_clr[`ERR_BUS_FAULT]))
    begin
      next_state.detail = {bus_opts.completion_chaining_enable,
                           bus_opts.completion_interrupt_enable,
                           2'h0, bus_opts.completion_code, 4'h0, bus_code};
    end

    // program set moves to the source side once it is idle and the queue has room
    move_now = s.prog_busy && !s.src_busy && (s.dq_count < DQ_DEPTH);
    pop_now  = dest_done && (s.dq_count != 3'h0);
    if (move_now)
    begin
      next_state.prog_busy = 1'b0;
      next_state.src_busy  = 1'b1;
      next_state.src_opts  = s.prog.opts;
      next_state.src_left  = s.prog.second_dim_count;
      next_state.dq[(s.dq_head + 2'(s.dq_count)) & DQ_WRAP] = s.prog.opts;
    end
    if (pop_now)
    begin
      next_state.dq_head = (s.dq_head + 2'h1) & DQ_WRAP;
    end
    next_state.dq_count = s.dq_count + 3'(move_now) - 3'(pop_now);

    // idle cycles after a read are the spacing minus one
    case (s.pacing)
      3'h1:    gap_load = 6'h03;
      3'h2:    gap_load = 6'h07;
      3'h3:    gap_load = 6'h0F;
      3'h4:    gap_load = 6'h1F;
      default: gap_load = 6'h00;
    endcase
    // the gap runs on while idle, so it also spaces reads of different requests
    if (s.gap != 6'h00)
    begin
      next_state.gap = s.gap - 6'h01;
    end
    else if (s.src_busy)
    begin
      next_state.read_cmd = 1'b1;
      next_state.gap      = gap_load;
      next_state.src_left = s.src_left - 16'h0001;
      if (s.src_left == 16'h0001)
      begin
        next_state.src_busy = 1'b0;
      end
    end

    // outstanding writes
    next_state.wr_pending = s.wr_pending + 8'(write_issued)
                          - 8'(write_status.valid && s.wr_pending != 8'h00);

    // error_recheck inverts the line for one cycle so an edge is seen either way
    next_state.error_recheck_gap = error_recheck_now && (s.flags != 4'h0);
    irq_cause = ((next_state.flags & next_state.mask) != 4'h0);
    next_state.irq = irq_cause ^ s.error_recheck_gap;
  end

  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      s        <= '0;
      s.mask   <= `MASK_RESET;
      s.pacing <= `PACING_RESET;
    end
    else
    begin
      s <= next_state;
    end
  end

  assign read_data            = s.rdata;
  assign program_set_occupied = s.prog_busy;
  assign read_cmd             = s.read_cmd;
  assign error_irq            = s.irq;

  // checks
  logic pend_any;
  logic status_rd;
  logic both_bad;
  assign pend_any  = (s.wr_pending != 8'h00);
  assign status_rd = reg_bus.rd && reg_bus.addr == `ADDR_ENGINE_STATUS;
  assign both_bad  = read_status.valid && read_status.code != 4'h0 &&
                     write_status.valid && write_status.code != 4'h0;

  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);

  a_write_pending_bit: assert property (status_rd |=> read_data[2] == $past(pend_any))
    else $error("write pending bit disagrees with outstanding count");
  a_source_active_bit: assert property (status_rd |=> read_data[1] == $past(s.src_busy))
    else $error("source active bit disagrees with source state");
  a_program_load: assert property (load_valid && !req_bad && !s.prog_busy
                                   |=> program_set_occupied)
    else $error("accepted load did not occupy program set");
  a_address_fault: assert property ((reg_bus.rd || reg_bus.wr) && !addr_valid
                                    |=> s.flags[3])
    else $error("unmapped access did not raise address fault");
  a_request_fault: assert property (load_valid && req_bad
                                    |=> s.flags[2] && $stable(s.prog))
    else $error("bad request not flagged or was loaded");
  a_bus_capture: assert property (bus_evt && !s.flags[0]
                                  |=> s.flags[0] && s.detail[3:0] == $past(bus_code))
    else $error("bus error not captured");
  a_irq_masked: assert property (!s.error_recheck_gap && (s.flags & s.mask) == 4'h0
                                 && flag_set == 4'h0 && !reg_bus.wr |=> !error_irq)
    else $error("interrupt raised without enabled flag");
  a_clear_keeps_detail: assert property (reg_bus.wr && reg_bus.addr == `ADDR_ERROR_CLEAR
                                         && reg_bus.wdata[3:0] == 4'h8 && !bus_evt
                                         && !flag_set[3] |=> !s.flags[3] && $stable(s.detail))
    else $error("address fault clear disturbed detail");
  a_clear_bus_wipes: assert property (reg_bus.wr && reg_bus.addr == `ADDR_ERROR_CLEAR
                                      && reg_bus.wdata[0] && !bus_evt
                                      |=> !s.flags[0] && s.detail == 18'h00000)
    else $error("bus fault clear did not wipe detail");
  a_write_priority: assert property (both_bad && !s.flags[0]
                                     |=> s.detail[3:0] == $past(write_status.code))
    else $error("write status did not win over read status");
  a_error_recheck_pulse: assert property (error_recheck_now && s.flags != 4'h0
                                 |=> s.error_recheck_gap ##1 error_irq == !$past(irq_cause))
    else $error("error evaluate did not pulse the line");
  a_pacing_gap: assert property (read_cmd && s.pacing == 3'h1 |=> !read_cmd [*3])
    else $error("reads closer than pacing allows");

  a_unmapped_zero: assert property (reg_bus.rd && !addr_valid
                                    |=> read_data == 32'h0000_0000)
    else $error("unmapped read returned nonzero data");
  a_irq_enabled: assert property (!s.error_recheck_gap && (s.flags & s.mask) != 4'h0
                                  && !reg_bus.wr |=> error_irq)
    else $error("enabled flag did not hold the interrupt");
  a_clear_zero_noop: assert property (reg_bus.wr && reg_bus.addr == `ADDR_ERROR_CLEAR
                                      && reg_bus.wdata[3:0] == 4'h0
                                      |=> s.flags == ($past(s.flags) | $past(flag_set)))
    else $error("zero clear changed a flag");
  a_detail_kept: assert property (s.flags[0] && !flag_clr[0] |=> $stable(s.detail))
    else $error("detail changed while bus flag held");
  a_occupied_holds: assert property (program_set_occupied && !move_now
                                     |=> program_set_occupied)
    else $error("program set freed without a move");
  a_queue_bound: assert property (s.dq_count <= DQ_DEPTH)
    else $error("destination queue count above its depth");
  a_idle_no_read: assert property (!s.src_busy |=> !read_cmd)
    else $error("read command while source side idle");
  a_back_to_back: assert property (s.src_busy && s.gap == 6'h00 |=> read_cmd)
    else $error("read held back with no gap pending");
  a_pacing_eight: assert property (read_cmd && s.pacing == 3'h2 |=> !read_cmd [*7])
    else $error("reads closer than eight cycle pacing allows");
  a_pending_rise: assert property (write_issued |=> pend_any)
    else $error("issued write not counted as pending");

  // the slowest gap is longer than a repetition may reach, so it is counted
  logic [5:0] since_read;
  logic       slow_prev;
  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      since_read <= 6'h3F;
      slow_prev  <= 1'b0;
    end
    else if (read_cmd)
    begin
      since_read <= 6'h00;
      slow_prev  <= (s.pacing == 3'h4);
    end
    else if (since_read != 6'h3F)
    begin
      since_read <= since_read + 6'h01;
    end
  end

  a_slow_pacing: assert property (read_cmd && slow_prev |-> since_read >= 6'h1F)
    else $error("reads closer than the slowest pacing allows");

  c_write_wins: cover property (both_bad ##1 s.flags[0]);
  c_bus_error: cover property (bus_evt && !s.flags[0] ##1 error_irq);
  c_error_recheck_pulse: cover property (error_recheck_now && s.flags != 4'h0 ##2 s.irq);
  c_paced_reads: cover property (read_cmd && s.pacing == 3'h1 ##4 read_cmd);
  c_queue_full: cover property (s.dq_count == DQ_DEPTH);

endmodule

//--- sim/dma_far_side.sv
// far side model: channel controller loads and endpoint status returns
`timescale 1ns/1ps
module dma_far_side
  import dma_engine_pkg::*;
(
  input  wire logic          clk,
  input  wire logic          reset,
  input  wire logic          go,
  input  wire move_request_t req,
  input  wire logic          both_go,
  input  wire logic          wr_go,
  input  wire logic [3:0]    rcode,
  input  wire logic [3:0]    wcode,
  input  wire logic          program_set_occupied,
  input  wire logic          read_cmd,
  output logic               load_valid,
  output move_request_t      load_req,
  output bus_status_t        read_status,
  output bus_status_t        write_status,
  output logic               write_issued
);
  logic       pend;
  logic       both;
  logic [3:0] wait_n;

  initial
  begin
    load_valid = 1'b0;
    load_req = '0;
    read_status = '0;
    write_status = '0;
    write_issued = 1'b0;
  end

  always @(posedge clk)
  begin
    // idle status lines show the inverse code so stale values never match
    read_status <= '{valid: 1'b0, code: ~read_status.code};
    write_status <= '{valid: 1'b0, code: ~write_status.code};
    load_valid <= 1'b0;
    write_issued <= wr_go | both_go;
    wait_n <= write_issued ? 4'h6 : (wait_n != 4'h0 ? wait_n - 4'h1 : 4'h0);
    if (both_go)
      both <= 1'b1;
    if (pend && !program_set_occupied && !load_valid)
    begin
      load_valid <= 1'b1;
      pend <= 1'b0;
    end
    if (go)
    begin
      pend <= 1'b1;
      load_req <= req;
    end
    if (read_cmd)
      read_status <= '{valid: 1'b1, code: 4'h0};
    // a slow write status retires the issued write
    if (wait_n == 4'h1)
    begin
      write_status <= '{valid: 1'b1, code: both ? wcode : 4'h0};
      if (both)
        read_status <= '{valid: 1'b1, code: rcode};
      both <= 1'b0;
    end
    if (reset)
    begin
      pend <= 1'b0;
      both <= 1'b0;
      load_valid <= 1'b0;
      wait_n <= 4'h0;
    end
  end
endmodule

//--- sim/dma_engine_status_tb_top.sv
// self-checking bench of the engine status block against the far side model
`timescale 1ns/1ps
`include "dma_engine_consts.svh"
module dma_engine_status_tb_top;
  import dma_engine_pkg::*;
  logic          clk = 1'b0;
  logic          reset = 1'b1;
  reg_req_t      rb = '0;
  logic [31:0]   rdata;
  logic          lv, occ, rcmd, irq, wiss;
  move_request_t lreq;
  move_request_t mreq = '0;
  bus_status_t   rs, ws;
  logic          go = 1'b0;
  logic          both_go = 1'b0;
  logic          wr_go = 1'b0;
  logic          dest_done = 1'b0;
  logic [3:0]    rcode = 4'h0;
  logic [3:0]    wcode = 4'h0;
  logic [31:0]   d;
  int            n_mismatch = 0;
  int            checks = 0;
  int            cyc = 0;
  int            cnt = 0;
  int            gaps[$];

  always #2 clk = ~clk;

  dma_engine_status #(.INSTANCE(0)) uut (.clk(clk), .reset(reset), .reg_bus(rb),
    .read_data(rdata), .load_valid(lv), .load_req(lreq), .read_status(rs),
    .write_status(ws), .write_issued(wiss), .dest_done(dest_done),
    .program_set_occupied(occ), .read_cmd(rcmd), .error_irq(irq));

  dma_far_side far (.clk(clk), .reset(reset), .go(go), .req(mreq), .both_go(both_go),
    .wr_go(wr_go), .rcode(rcode), .wcode(wcode), .program_set_occupied(occ),
    .read_cmd(rcmd), .load_valid(lv), .load_req(lreq), .read_status(rs),
    .write_status(ws), .write_issued(wiss));

  task automatic test_done();
    $display("checks %0d mismatches %0d", checks, n_mismatch);
    if (n_mismatch == 0 && checks > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask

  // read command spacing, counted in clock cycles; sampled mid-cycle so the pulse is settled
  always @(negedge clk)
  begin
    cyc++;
    if (rcmd === 1'b1)
    begin
      gaps.push_back(cnt);
      cnt = 1;
    end
    else
      cnt++;
    if (cyc == 20000)
    begin
      n_mismatch++;
      test_done();
    end
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp)
    begin
      n_mismatch++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic rd(input logic [11:0] a);
    @(posedge clk);
    rb <= '{rd: 1'b1, wr: 1'b0, addr: a, wdata: 32'h0};
    @(posedge clk);
    rb <= '0;
    #1 d = rdata;
  endtask

  task automatic wr(input logic [11:0] a, input logic [31:0] v);
    @(posedge clk);
    rb <= '{rd: 1'b0, wr: 1'b1, addr: a, wdata: v};
    @(posedge clk);
    rb <= '0;
  endtask

  task automatic after_edges(input int n, input logic exp);
    repeat (n) @(posedge clk);
    #1 chk(irq, exp);
  endtask

  task automatic load(input move_request_t r);
    int k;
    @(posedge clk);
    mreq <= r;
    go <= 1'b1;
    @(posedge clk);
    go <= 1'b0;
    for (k = 0; k < 300 && lv !== 1'b1; k++)
      @(posedge clk) #1;
  endtask

  task automatic drain(input int n);
    repeat (n)
    begin
      @(posedge clk);
      dest_done <= 1'b1;
      @(posedge clk);
      dest_done <= 1'b0;
      repeat (6) @(posedge clk);
    end
  endtask

  task automatic fire(input logic [3:0] r, input logic [3:0] w);
    @(posedge clk);
    rcode <= r;
    wcode <= w;
    both_go <= 1'b1;
    @(posedge clk);
    both_go <= 1'b0;
    repeat (10) @(posedge clk);
  endtask

  function automatic move_request_t mk(input logic [15:0] a, input logic [15:0] b,
                                       input logic s);
    move_request_t r;
    r = '0;
    r.opts.completion_chaining_enable = 1'b1;
    r.opts.completion_code = 6'h15;
    r.opts.fifo_width = 3'h2;
    r.opts.source_addr_mode = s;
    r.src_addr_low = 5'h1;
    r.first_dim_bytes = a;
    r.second_dim_count = b;
    return r;
  endfunction

  task automatic t_regs();
    rd(`ADDR_ENGINE_STATUS);
    chk(d, 32'h0000_0100);
    wr(`ADDR_ACTIVE_OPTIONS, 32'hFFFF_FFFF);
    rd(`ADDR_ACTIVE_OPTIONS);
    chk(d, 32'h0);
    rd(`ADDR_ERROR_FLAGS);
    chk(d, 32'h0);
    rd(12'hFFC);
    chk(d, 32'h0);
    rd(`ADDR_ERROR_FLAGS);
    chk(d, 32'h8);
    chk(irq, 1'b0);
    wr(`ADDR_ERROR_MASK, 32'h8);
    after_edges(1, 1'b1);
    wr(`ADDR_ERROR_CLEAR, 32'h0);
    rd(`ADDR_ERROR_FLAGS);
    chk(d, 32'h8);
    wr(`ADDR_ERROR_CLEAR, 32'h8);
    rd(`ADDR_ERROR_FLAGS);
    chk(d, 32'h0);
    chk(irq, 1'b0);
    $display("test t_regs done");
  endtask

  task automatic t_bad();
    move_request_t bad[3];
    int i;
    bad[0] = mk(16'h0, 16'h3, 1'b0);
    bad[1] = mk(16'h10, 16'h0, 1'b0);
    bad[2] = mk(16'h10, 16'h3, 1'b1);
    for (i = 0; i < 3; i++)
    begin
      load(bad[i]);
      rd(`ADDR_ERROR_FLAGS);
      chk(d, 32'h4);
      chk(occ, 1'b0);
      wr(`ADDR_ERROR_CLEAR, 32'h4);
    end
    $display("test t_bad done");
  endtask

  task automatic t_pace();
    int sp[5] = '{1, 4, 8, 16, 32};
    int p;
    for (p = 0; p < 5; p++)
    begin
      // pacing only changes while the engine is idle
      wr(`ADDR_READ_PACING, 32'(p));
      rd(`ADDR_READ_PACING);
      chk(d, 32'(p));
      gaps.delete();
      load(mk(16'h10, 16'h2, 1'b0));
      load(mk(16'h10, 16'h2, 1'b0));
      for (int k = 0; k < 400 && gaps.size() < 4; k++)
        @(posedge clk);
      chk(gaps.size(), 4);
      chk(gaps[1], sp[p]);
      chk(gaps[3], sp[p]);
      if (p > 1)
        chk(gaps[2], sp[p]);
      repeat (4) @(posedge clk);
      rd(`ADDR_ENGINE_STATUS);
      chk(d, 32'h0000_0120);
      drain(2);
      rd(`ADDR_ENGINE_STATUS);
      chk(d, 32'h0000_0100);
    end
    wr(`ADDR_READ_PACING, 32'h0);
    $display("test t_pace done");
  endtask

  task automatic t_write();
    @(posedge clk);
    wr_go <= 1'b1;
    @(posedge clk);
    wr_go <= 1'b0;
    rd(`ADDR_ENGINE_STATUS);
    chk(d, 32'h0000_0104);
    repeat (12) @(posedge clk);
    rd(`ADDR_ENGINE_STATUS);
    chk(d, 32'h0000_0100);
    $display("test t_write done");
  endtask

  task automatic t_bus();
    load(mk(16'h10, 16'h1, 1'b0));
    load(mk(16'h10, 16'h1, 1'b0));
    load(mk(16'h10, 16'h1, 1'b0));
    repeat (6) @(posedge clk);
    rd(`ADDR_ENGINE_STATUS);
    chk(d, 32'h0000_0121);
    wr(`ADDR_ERROR_MASK, 32'h1);
    fire(4'h3, 4'h0);
    rd(`ADDR_ERROR_FLAGS);
    chk(d, 32'h1);
    rd(`ADDR_ERROR_DETAIL);
    chk(d, 32'h0002_1503);
    chk(irq, 1'b1);
    wr(`ADDR_ERROR_COMMAND, 32'h1);
    after_edges(1, 1'b0);
    after_edges(1, 1'b1);
    rd(12'hFFC);
    wr(`ADDR_ERROR_CLEAR, 32'h8);
    rd(`ADDR_ERROR_DETAIL);
    chk(d, 32'h0002_1503);
    wr(`ADDR_ERROR_CLEAR, 32'h1);
    rd(`ADDR_ERROR_FLAGS);
    chk(d, 32'h0);
    rd(`ADDR_ERROR_DETAIL);
    chk(d, 32'h0);
    fire(4'h3, 4'hB);
    rd(`ADDR_ERROR_DETAIL);
    chk(d, 32'h0002_150B);
    wr(`ADDR_ERROR_CLEAR, 32'h1);
    wr(`ADDR_ERROR_MASK, 32'h0);
    rd(12'hFFC);
    wr(`ADDR_ERROR_COMMAND, 32'h1);
    after_edges(1, 1'b1);
    after_edges(1, 1'b0);
    wr(`ADDR_ERROR_CLEAR, 32'h8);
    wr(`ADDR_ERROR_COMMAND, 32'h1);
    after_edges(1, 1'b0);
    drain(3);
    rd(`ADDR_ENGINE_STATUS);
    chk(d, 32'h0000_1100);
    $display("test t_bus done");
  endtask

  initial
  begin
    repeat (10) @(posedge clk);
    reset <= 1'b0;
    t_regs();
    t_bad();
    t_pace();
    t_write();
    t_bus();
    test_done();
  end
endmodule
